// [logic/crs_map.svh]
// register offsets, field positions and reset values of the cpu register set
// assumes: included by bare name from the package and the design file
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// ----------------------------------------
// apb byte offsets
// ----------------------------------------
`define CRS_OFS_COMMAND  8'h00
`define CRS_OFS_OPERAND  8'h04
`define CRS_OFS_ACC      8'h08
`define CRS_OFS_INDEX    8'h0C
`define CRS_OFS_STACK    8'h10
`define CRS_OFS_PC       8'h14
`define CRS_OFS_CCR      8'h18
`define CRS_OFS_STATUS   8'h1C
// ----------------------------------------
// condition code bit positions
// ----------------------------------------
`define CRS_CCR_OVF      7
`define CRS_CCR_HALF     4
`define CRS_CCR_MASK     3
`define CRS_CCR_NEG      2
`define CRS_CCR_ZERO     1
`define CRS_CCR_CARRY    0
`define CRS_CCR_ONES     2'h3
// ----------------------------------------
// reset values and command field width
// ----------------------------------------
`define CRS_SP_RESET     16'h00FF
`define CRS_HI_RESET     8'h00
`define CRS_SP_LOW_RESET 8'hFF
`define CRS_CMD_W        5
`endif

// [logic/crs_pkg.sv]
// types shared by the cpu register set
// assumes: crs_map.svh is on the include path
package crs_pkg;
  `include "crs_map.svh"
  typedef enum logic [`CRS_CMD_W-1:0] {
    CMD_NOP      = 5'h00, CMD_LDA      = 5'h01, CMD_LDHX     = 5'h02, CMD_LDSP    = 5'h03,
    CMD_ADD      = 5'h04, CMD_ADC      = 5'h05, CMD_SUB      = 5'h06, CMD_DECADJ  = 5'h07,
    CMD_ADDSTK   = 5'h08, CMD_STKLOW   = 5'h09, CMD_CLRMASK  = 5'h0A, CMD_SETMASK = 5'h0B,
    CMD_TOFLAGS  = 5'h0C, CMD_FROMFLAG = 5'h0D, CMD_INCX     = 5'h0E, CMD_DECX    = 5'h0F,
    CMD_CLRX     = 5'h10, CMD_COMX     = 5'h11, CMD_NEGX     = 5'h12, CMD_LSLX    = 5'h13,
    CMD_ROLX     = 5'h14, CMD_LSRX     = 5'h15, CMD_RORX     = 5'h16, CMD_FETCH   = 5'h17,
    CMD_JUMP     = 5'h18, CMD_BRGT     = 5'h19, CMD_BRGE     = 5'h1A, CMD_BRLE    = 5'h1B,
    CMD_BRLT     = 5'h1C, CMD_INTR     = 5'h1D
  } crs_cmd_t;
  typedef enum logic [1:0] {
    ST_LOAD_VEC = 2'h0,
    ST_RUN      = 2'h1
  } crs_state_t;
  typedef struct packed {
    logic v;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } crs_flags_t;
  typedef struct packed {
    logic       c;
    logic       h;
    logic       v;
    logic [7:0] res;
  } crs_sum_t;
endpackage

// [logic/crs_cpu_regs.sv]
// programmer-visible register set and condition codes of an 8-bit cpu, apb slave
// assumes: one clock, inputs synchronous to it, resetVector holds the fetched vector
//
// What this block does
// - 8-bit accumulator feeds alu operand; changed only by commands
// - accumulator keeps its value through reset
// - index pair is high and low byte; full 16 bits form the base pointer
// - low index byte works alone: clear, inc, dec, complement, negate, shifts
// - reset clears high index byte, low index byte is kept
// - 16-bit stack pointer addresses next free stack location
// - add-to-stack sign-extends an 8-bit immediate and adds it
// - reset loads stack pointer with 0x00FF
// - stack low reset touches only low byte of stack pointer
// - program counter increments by one on each sequential fetch
// - jump, taken branch, interrupt load pc; flagged as change of flow
// - after reset pc is loaded with the reset vector
// - condition codes 8 bits; bits 6 and 5 always read one
// - overflow flag bit 7 follows two's complement overflow; signed branches test it
// - half carry bit 4 set on carry from bit 3 in add or add-with-carry
// - decimal adjust uses half carry and carry to correct bcd sum
// - mask bit 3 blocks maskable interrupts while set
// - interrupt sets mask after stacking, before service code
// - no interrupt taken right after clearing a set mask
// - negative flag bit 2 copies bit 7 of results and 8-bit loads, bit 15 of 16-bit loads
// - zero flag bit 1 set on all-zero 8 or 16 bit result
// - carry bit 0 from add carry, subtract borrow, shifts and rotates
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "crs_map.svh"
module crs_cpu_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [15:0]       resetVector,
  input  wire logic              irqReq,
  output logic [7:0]             accOut,
  output logic [15:0]            indexBase,
  output logic [15:0]            stackPtr,
  output logic [15:0]            progCnt,
  output logic                   flowChange,
  output logic                   irqTake
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  crs_pkg::crs_state_t state;
  crs_pkg::crs_flags_t flags;
  logic [7:0]          acc;
  logic [7:0]          idxHi;
  logic [7:0]          idxLo;
  logic [15:0]         sp;
  logic [15:0]         pc;
  logic [15:0]         opnd;
  logic                inhibit;
  logic [7:0]          next_acc;
  logic [7:0]          next_lo;
  logic [7:0]          next_hi;
  logic [15:0]         next_sp;
  logic [15:0]         next_pc;
  crs_pkg::crs_flags_t next_flags;
  logic                next_flow;
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic              apbDone  = psel & penable & pready;
  wire logic              apbWr    = apbDone & pwrite;
  wire logic [7:0]        ofs      = paddr[7:0];
  wire logic              hitCmd   = ofs == `CRS_OFS_COMMAND;
  wire logic              hitOpnd  = ofs == `CRS_OFS_OPERAND;
  wire logic              mapped   = (ofs[1:0] == 2'h0) && (ofs <= `CRS_OFS_STATUS) && (paddr[ADDR_W-1:0] == ADDR_W'(ofs));
  wire logic              exec     = apbWr & hitCmd & (state == crs_pkg::ST_RUN);
  wire crs_pkg::crs_cmd_t cmd      = crs_pkg::crs_cmd_t'(pwdata[`CRS_CMD_W-1:0]);
  wire logic [7:0]        ccrView  = {flags.v, `CRS_CCR_ONES, flags.h, flags.i, flags.n, flags.z, flags.c};
  wire logic [31:0]       rdMux    = (ofs == `CRS_OFS_OPERAND) ? {16'h0000, opnd} :
                                     (ofs == `CRS_OFS_ACC)     ? {24'h000000, acc} :
                                     (ofs == `CRS_OFS_INDEX)   ? {16'h0000, idxHi, idxLo} :
                                     (ofs == `CRS_OFS_STACK)   ? {16'h0000, sp} :
                                     (ofs == `CRS_OFS_PC)      ? {16'h0000, pc} :
                                     (ofs == `CRS_OFS_CCR)     ? {24'h000000, ccrView} :
                                     (ofs == `CRS_OFS_STATUS)  ? {30'h0, inhibit, state == crs_pkg::ST_RUN} :
                                     32'h00000000;

  // no wait state: pready rises in the first access cycle so prdata can be a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~pready;
      prdata  <= (psel & ~pwrite & mapped) ? rdMux : 32'h00000000;
      pslverr <= psel & ~pready & ~mapped;
    end
  end

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic crs_pkg::crs_sum_t addBytes(input logic [7:0] a, input logic [7:0] b, input logic cin,
                                                 input logic sub);
    logic [7:0] bb;
    logic [4:0] lo;
    logic [8:0] full;
    crs_pkg::crs_sum_t r;
    bb     = sub ? ~b : b;
    lo     = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
    full   = {1'b0, a} + {1'b0, bb} + {8'h00, cin ^ sub};
    r.res  = full[7:0];
    r.h    = lo[4];
    r.c    = full[8] ^ sub;
    r.v    = (a[7] == bb[7]) && (full[7] != a[7]);
    return r;
  endfunction

  // bcd correction from the previous add result held in acc
  function automatic logic [8:0] decAdjust(input logic [7:0] a, input logic h, input logic c);
    logic       up;
    logic       lo;
    logic [7:0] corr;
    up   = c || (a[7:4] > 4'h9) || ((a[7:4] >= 4'h9) && (a[3:0] > 4'h9));
    lo   = h || (a[3:0] > 4'h9);
    corr = {(up ? 4'h6 : 4'h0), (lo ? 4'h6 : 4'h0)};
    return {up, a + corr};
  endfunction

  wire crs_pkg::crs_sum_t sumAdd   = addBytes(acc, opnd[7:0], 1'b0, 1'b0);
  wire crs_pkg::crs_sum_t sumAdc   = addBytes(acc, opnd[7:0], flags.c, 1'b0);
  wire crs_pkg::crs_sum_t sumSub   = addBytes(acc, opnd[7:0], 1'b0, 1'b1);
  wire logic [8:0]        dadj     = decAdjust(acc, flags.h, flags.c);
  wire logic [15:0]       relOfs   = {{8{opnd[7]}}, opnd[7:0]};
  wire logic              nXorV    = flags.n ^ flags.v;
  wire logic              clearsI  = (cmd == crs_pkg::CMD_CLRMASK) ||
                                     ((cmd == crs_pkg::CMD_TOFLAGS) && !acc[`CRS_CCR_MASK]);

  // ----------------------------------------
  // next-state datapath
  // ----------------------------------------
  always_comb begin
    next_acc   = acc;
    next_lo    = idxLo;
    next_hi    = idxHi;
    next_sp    = sp;
    next_pc    = pc;
    next_flags = flags;
    next_flow  = 1'b0;
    case (cmd)
      crs_pkg::CMD_LDA: begin
        next_acc     = opnd[7:0];
        next_flags.n = opnd[7];
        next_flags.z = opnd[7:0] == 8'h00;
        next_flags.v = 1'b0;
      end
      crs_pkg::CMD_LDHX: begin
        next_hi      = opnd[15:8];
        next_lo      = opnd[7:0];
        next_flags.n = opnd[15];
        next_flags.z = opnd == 16'h0000;
        next_flags.v = 1'b0;
      end
      crs_pkg::CMD_LDSP:   next_sp = opnd;
      crs_pkg::CMD_ADD, crs_pkg::CMD_ADC, crs_pkg::CMD_SUB: begin
        next_acc = (cmd == crs_pkg::CMD_ADD) ? sumAdd.res : (cmd == crs_pkg::CMD_ADC) ? sumAdc.res : sumSub.res;
        next_flags.v = (cmd == crs_pkg::CMD_ADD) ? sumAdd.v : (cmd == crs_pkg::CMD_ADC) ? sumAdc.v : sumSub.v;
        next_flags.c = (cmd == crs_pkg::CMD_ADD) ? sumAdd.c : (cmd == crs_pkg::CMD_ADC) ? sumAdc.c : sumSub.c;
        if (cmd != crs_pkg::CMD_SUB) begin
          next_flags.h = (cmd == crs_pkg::CMD_ADD) ? sumAdd.h : sumAdc.h;
        end
        next_flags.n = next_acc[7];
        next_flags.z = next_acc == 8'h00;
      end
      crs_pkg::CMD_DECADJ: begin
        next_acc     = dadj[7:0];
        next_flags.c = dadj[8];
        next_flags.n = dadj[7];
        next_flags.z = dadj[7:0] == 8'h00;
      end
      crs_pkg::CMD_ADDSTK:  next_sp = sp + relOfs;
      crs_pkg::CMD_STKLOW:  next_sp = {sp[15:8], `CRS_SP_LOW_RESET};
      crs_pkg::CMD_CLRMASK: next_flags.i = 1'b0;
      crs_pkg::CMD_SETMASK: next_flags.i = 1'b1;
      crs_pkg::CMD_TOFLAGS: begin
        // bits 6 and 5 of acc are dropped on purpose
        next_flags = {acc[`CRS_CCR_OVF], acc[`CRS_CCR_HALF], acc[`CRS_CCR_MASK],
                      acc[`CRS_CCR_NEG], acc[`CRS_CCR_ZERO], acc[`CRS_CCR_CARRY]};
      end
      crs_pkg::CMD_FROMFLAG: next_acc = ccrView;
      crs_pkg::CMD_INCX, crs_pkg::CMD_DECX, crs_pkg::CMD_CLRX, crs_pkg::CMD_COMX, crs_pkg::CMD_NEGX: begin
        next_lo = (cmd == crs_pkg::CMD_INCX) ? idxLo + 8'h01 :
                  (cmd == crs_pkg::CMD_DECX) ? idxLo - 8'h01 :
                  (cmd == crs_pkg::CMD_CLRX) ? 8'h00 :
                  (cmd == crs_pkg::CMD_COMX) ? ~idxLo : 8'h00 - idxLo;
        next_flags.v = (cmd == crs_pkg::CMD_INCX) ? (idxLo == 8'h7F) :
                       (cmd == crs_pkg::CMD_DECX) ? (idxLo == 8'h80) :
                       (cmd == crs_pkg::CMD_NEGX) ? (idxLo == 8'h80) : 1'b0;
        if (cmd == crs_pkg::CMD_COMX) begin
          next_flags.c = 1'b1;
        end else if (cmd == crs_pkg::CMD_NEGX) begin
          next_flags.c = idxLo != 8'h00;
        end
        next_flags.n = next_lo[7];
        next_flags.z = next_lo == 8'h00;
      end
      crs_pkg::CMD_LSLX, crs_pkg::CMD_ROLX, crs_pkg::CMD_LSRX, crs_pkg::CMD_RORX: begin
        next_lo = (cmd == crs_pkg::CMD_LSLX) ? {idxLo[6:0], 1'b0} :
                  (cmd == crs_pkg::CMD_ROLX) ? {idxLo[6:0], flags.c} :
                  (cmd == crs_pkg::CMD_LSRX) ? {1'b0, idxLo[7:1]} : {flags.c, idxLo[7:1]};
        next_flags.c = (cmd == crs_pkg::CMD_LSLX || cmd == crs_pkg::CMD_ROLX) ? idxLo[7] : idxLo[0];
        next_flags.n = next_lo[7];
        next_flags.z = next_lo == 8'h00;
        next_flags.v = next_lo[7] ^ next_flags.c;
      end
      crs_pkg::CMD_FETCH: next_pc = pc + 16'h0001;
      crs_pkg::CMD_JUMP: begin
        next_pc   = opnd;
        next_flow = 1'b1;
      end
      crs_pkg::CMD_BRGT, crs_pkg::CMD_BRGE, crs_pkg::CMD_BRLE, crs_pkg::CMD_BRLT: begin
        // signed compares read the overflow flag with negative; greater and less-or-equal also read zero
        if (((cmd == crs_pkg::CMD_BRGT) && !(flags.z | nXorV)) ||
            ((cmd == crs_pkg::CMD_BRGE) && !nXorV) ||
            ((cmd == crs_pkg::CMD_BRLE) && (flags.z | nXorV)) ||
            ((cmd == crs_pkg::CMD_BRLT) && nXorV)) begin
          next_pc   = pc + relOfs;
          next_flow = 1'b1;
        end
      end
      crs_pkg::CMD_INTR: begin
        // pc, x, a and ccr occupy five stacked bytes
        next_sp      = sp - 16'h0005;
        next_flags.i = 1'b1;
        next_pc      = opnd;
        next_flow    = 1'b1;
      end
      default: next_flow = 1'b0;
    endcase
  end

  // ----------------------------------------
  // register updates
  // ----------------------------------------
  // no reset on acc and low index byte: their contents survive reset
  always_ff @(posedge ref_clk) begin
    if (exec) begin
      acc   <= next_acc;
      idxLo <= next_lo;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idxHi <= `CRS_HI_RESET;
      sp    <= `CRS_SP_RESET;
      flags <= '{v: 1'b0, h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
    end else if (exec) begin
      idxHi <= next_hi;
      sp    <= next_sp;
      flags <= next_flags;
    end
  end

  // pc takes the vector in the first cycle after release, never from a port under reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= crs_pkg::ST_LOAD_VEC;
      pc    <= 16'h0000;
    end else begin
      case (state)
        crs_pkg::ST_LOAD_VEC: begin
          pc    <= resetVector;
          state <= crs_pkg::ST_RUN;
        end
        crs_pkg::ST_RUN: pc <= exec ? next_pc : pc;
        default: state <= crs_pkg::ST_LOAD_VEC;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd <= 16'h0000;
    end else if (apbWr & hitOpnd) begin
      opnd <= pwdata[15:0];
    end
  end

  // mask clear with mask set shields exactly one following instruction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inhibit <= 1'b0;
    end else if (exec) begin
      inhibit <= clearsI & flags.i;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flowChange <= 1'b0;
      irqTake    <= 1'b0;
    end else begin
      flowChange <= exec & next_flow;
      irqTake    <= irqReq & ~flags.i & ~inhibit & (state == crs_pkg::ST_RUN);
    end
  end

  assign accOut    = acc;
  assign indexBase = {idxHi, idxLo};
  assign stackPtr  = sp;
  assign progCnt   = pc;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_sp_reset_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == crs_pkg::ST_LOAD_VEC) |-> (sp == `CRS_SP_RESET) && (idxHi == `CRS_HI_RESET))
    else $error("stack pointer or high index byte wrong after reset");
  a_pc_vector_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == crs_pkg::ST_LOAD_VEC) |=> (pc == $past(resetVector)) && (state == crs_pkg::ST_RUN))
    else $error("reset vector not loaded into pc");
  a_pc_fetch_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_FETCH) |=> (pc == $past(pc) + 16'h0001) && !flowChange)
    else $error("pc did not step by one on fetch");
  a_ccr_fixed_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && penable && pready && !pwrite && ofs == `CRS_OFS_CCR) |-> (prdata[6:5] == `CRS_CCR_ONES))
    else $error("ccr bits 6 and 5 not read as one");
  a_stack_add_sext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_ADDSTK) |=> (sp == $past(sp) + {{8{$past(opnd[7])}}, $past(opnd[7:0])}))
    else $error("add to stack not sign extended");
  a_stack_low_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_STKLOW) |=> (sp[15:8] == $past(sp[15:8])) && (sp[7:0] == `CRS_SP_LOW_RESET))
    else $error("stack low reset touched high byte");
  a_intr_mask_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_INTR) |=> flags.i && (pc == $past(opnd)) && flowChange && (sp == $past(sp) - 16'h0005))
    else $error("interrupt entry did not set mask and load pc");
  a_mask_blocks_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flags.i |=> !irqTake)
    else $error("interrupt taken while masked");
  a_clear_shadow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_CLRMASK && flags.i) |=> inhibit ##1 !irqTake)
    else $error("interrupt taken right after mask clear");
  a_half_carry_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_ADD) |=> flags.h == (({1'b0, $past(acc[3:0])} + {1'b0, $past(opnd[3:0])}) > 5'h0F))
    else $error("half carry wrong after add");
  a_wide_load_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_LDHX) |=> (flags.n == $past(opnd[15])) && (flags.z == ($past(opnd) == 16'h0000)))
    else $error("16-bit load flags wrong");
  a_branch_signed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_BRGE && !nXorV) |=> flowChange && (pc == $past(pc) + $past(relOfs)))
    else $error("signed branch not taken");
  a_shift_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_LSLX) |=> (flags.c == $past(idxLo[7])) && (idxLo == {$past(idxLo[6:0]), 1'b0}))
    else $error("low byte shift or its carry wrong");
  a_sub_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_SUB) |=> flags.c == ($past(opnd[7:0]) > $past(acc)))
    else $error("borrow wrong after subtract");
  a_load_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_LDA) |=> flags.z == ($past(opnd[7:0]) == 8'h00))
    else $error("zero flag wrong after load");
  a_high_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && cmd == crs_pkg::CMD_DECX) |=> idxHi == $past(idxHi))
    else $error("low byte decrement touched high byte");
endmodule

// [tb/crs_far_model.sv]
// far side of the register set: the vector fetch and the interrupt source
// assumes: one clock; the bench decides when an interrupt is wanted
`timescale 1ns/10ps
module crs_far_model #(
  parameter logic [15:0] VEC = 16'hC000
) (
  input  wire logic        ref_clk,
  input  wire logic        irqWant,
  output logic [15:0]      resetVector,
  output logic             irqReq
);
  // the vector is a plain constant; no memory is modelled behind it
  assign resetVector = VEC;
  // a level request, presented one edge after the bench asks for it
  always_ff @(posedge ref_clk) begin
    irqReq <= irqWant;
  end
endmodule

// [tb/tb_cpu_register_set_ccr.sv]
// self-checking bench for the cpu register set, driven over apb
// assumes: crs_pkg compiled first, crs_map.svh on the include path
`timescale 1ns/10ps
module tb_cpu_register_set_ccr;
  localparam logic [15:0] VEC = 16'hC000;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irqWant = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0, rd, prdata;
  logic        pready, pslverr, flowChange, irqTake, err, irqReq;
  logic [15:0] resetVector, indexBase, stackPtr, progCnt, keep;
  logic [7:0]  accOut;
  int          fails = 0, total_checks = 0, cyc = 0;
  // ----------------------------------------
  // clock, parts and timeout
  // ----------------------------------------
  initial forever #25 ref_clk = ~ref_clk;
  crs_far_model #(.VEC(VEC)) far_u (.ref_clk(ref_clk), .irqWant(irqWant), .resetVector(resetVector), .irqReq(irqReq));
  crs_cpu_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .resetVector(resetVector), .irqReq(irqReq), .accOut(accOut), .indexBase(indexBase),
    .stackPtr(stackPtr), .progCnt(progCnt), .flowChange(flowChange), .irqTake(irqTake));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      stop_test();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // the slave picks the length of the access; only the timeout caps it
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [4:0] op, input logic [15:0] v);
    apb(1'b1, 8'h04, {16'h0000, v});
    apb(1'b1, 8'h00, {27'h0, op});
    // results land at the completing edge; look only once it has settled
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rreg(8'h10, 32'h0000_00FF);
    rreg(8'h14, {16'h0000, VEC});
    rreg(8'h18, 32'h0000_0068);
    chk(32'(indexBase[15:8]), 32'h0);
    rreg(8'h20, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic t_alu;
    cmd(crs_pkg::CMD_LDA, 16'h0038);
    cmd(crs_pkg::CMD_ADD, 16'h000F);
    chk(32'(accOut), 32'h47);
    rreg(8'h18, 32'h78);
    cmd(crs_pkg::CMD_ADC, 16'h00C0);
    chk(32'(accOut), 32'h07);
    rreg(8'h18, 32'h69);
    cmd(crs_pkg::CMD_SUB, 16'h0008);
    rreg(8'h18, 32'h6D);
    cmd(crs_pkg::CMD_LDA, 16'h007F);
    cmd(crs_pkg::CMD_ADD, 16'h0001);
    rreg(8'h18, 32'hFC);
    cmd(crs_pkg::CMD_LDA, 16'h0009);
    cmd(crs_pkg::CMD_ADD, 16'h0008);
    cmd(crs_pkg::CMD_DECADJ, 16'h0000);
    chk(32'(accOut), 32'h17);
  endtask
  task automatic t_index;
    cmd(crs_pkg::CMD_LDHX, 16'h8000);
    chk(32'(indexBase), 32'h8000);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[2:1]), 32'h2);
    cmd(crs_pkg::CMD_LDHX, 16'h0000);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[2:1]), 32'h1);
    cmd(crs_pkg::CMD_DECX, 16'h0000);
    chk(32'(indexBase), 32'h00FF);
  endtask
  task automatic t_stack;
    cmd(crs_pkg::CMD_LDSP, 16'h1234);
    cmd(crs_pkg::CMD_ADDSTK, 16'h00F0);
    chk(32'(stackPtr), 32'h1224);
    cmd(crs_pkg::CMD_STKLOW, 16'h0000);
    chk(32'(stackPtr), 32'h12FF);
  endtask
  task automatic t_flow;
    keep = progCnt;
    cmd(crs_pkg::CMD_FETCH, 16'h0000);
    #1 chk(32'(flowChange), 32'h0);
    chk(32'(progCnt), 32'(keep + 16'h0001));
    cmd(crs_pkg::CMD_JUMP, 16'h4000);
    #1 chk(32'(flowChange), 32'h1);
    chk(32'(progCnt), 32'h4000);
  endtask
  task automatic t_irq;
    @(posedge ref_clk);
    irqWant <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(irqTake), 32'h0);
    cmd(crs_pkg::CMD_CLRMASK, 16'h0000);
    repeat (3) @(posedge ref_clk);
    chk(32'(irqTake), 32'h0);
    rreg(8'h1C, 32'h3);
    cmd(crs_pkg::CMD_NOP, 16'h0000);
    repeat (3) @(posedge ref_clk);
    chk(32'(irqTake), 32'h1);
    keep = stackPtr;
    cmd(crs_pkg::CMD_INTR, 16'h2000);
    #1 chk(32'(progCnt), 32'h2000);
    chk(32'(stackPtr), 32'(keep - 16'h0005));
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[3]), 32'h1);
    repeat (3) @(posedge ref_clk);
    chk(32'(irqTake), 32'h0);
    irqWant <= 1'b0;
  endtask
  task automatic t_flags;
    cmd(crs_pkg::CMD_LDA, 16'h0009);
    cmd(crs_pkg::CMD_TOFLAGS, 16'h0000);
    rreg(8'h18, 32'h0000_0069);
    cmd(crs_pkg::CMD_LDA, 16'h0000);
    cmd(crs_pkg::CMD_TOFLAGS, 16'h0000);
    rreg(8'h1C, 32'h3);
    cmd(crs_pkg::CMD_FROMFLAG, 16'h0000);
    chk(32'(accOut), 32'h60);
    keep = progCnt;
    cmd(crs_pkg::CMD_BRLT, 16'h0010);
    chk(32'(progCnt), 32'(keep));
    cmd(crs_pkg::CMD_BRGE, 16'h0010);
    chk(32'(flowChange), 32'h1);
    chk(32'(progCnt), 32'(keep + 16'h0010));
    cmd(crs_pkg::CMD_LSLX, 16'h0000);
    chk(32'(indexBase), 32'h00FE);
    rreg(8'h18, 32'h65);
  endtask
  task automatic t_reset2;
    cmd(crs_pkg::CMD_LDA, 16'h005C);
    cmd(crs_pkg::CMD_LDHX, 16'h5AA5);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(accOut), 32'h5C);
    chk(32'(indexBase), 32'h00A5);
    chk(32'(stackPtr), 32'h00FF);
    chk(32'(progCnt), {16'h0000, VEC});
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_alu();
    t_index();
    t_stack();
    t_flow();
    t_irq();
    t_flags();
    t_reset2();
    stop_test();
  end
endmodule
